// ### core/pin_route_mux.sv
// Purpose: One selector-driven pin multiplexer with registered output
// Assumes: Pins already synchronised to aclk
// Notes:   Codes 16..31 all give a constant low
`timescale 1ns/1ps
module pin_route_mux
  import pin_select_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Selection
  input  wire logic [SEL_W-1:0]  sel,
  input  wire logic [PIN_N-1:0]  pins,
  // Routed peripheral input
  output logic                   route_q
);

  logic route_d;

  // ----------------------------------------------------------------
  // Pick a pin or the ground rail
  // ----------------------------------------------------------------
  always_comb begin
    if (sel[SEL_W-1]) begin
      route_d = 1'b0;
    end else begin
      route_d = pins[sel[SEL_W-2:0]];
    end
  end

  // Register so the peripheral sees a clean edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route_q <= 1'b0;
    end else begin
      route_q <= route_d;
    end
  end

endmodule

// ### core/pin_select_pkg.sv
// Purpose: Shared constants for the remappable input selector block
// Assumes: AXI4-Lite, 32-bit data, one aligned word per register
// Notes:   Selector i lives in register SEL_OFF[i] at bit SEL_LSB[i]
package pin_select_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 6;
  localparam int SEL_W   = 5;
  localparam int PIN_N   = 16;
  localparam int SEL_N   = 13;
  localparam int REG_W   = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_EXT_INT_TWO  = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_TIMER_CLOCK  = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE_LOW  = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE_HIGH = 6'h0C;
  localparam logic [ADDR_W-1:0] OFF_COMPARE_FLT  = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_UART         = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_SPI_DATA_CLK = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_SPI_SELECT   = 6'h1C;
  localparam logic [ADDR_W-1:0] OFF_OSC_CONTROL  = 6'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int FIELD_LO = 0;
  localparam int FIELD_HI = 8;
  localparam logic [SEL_W-1:0] SEL_RESET = 5'h1F;
  localparam int LOCK_BIT    = 6;
  localparam int ONE_WAY_BIT = 5;
  localparam logic [7:0] UNLOCK_KEY_ONE = 8'h46;
  localparam logic [7:0] UNLOCK_KEY_TWO = 8'h57;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Order: ext int two, timer two, timer three, capture 1/2/7/8,
  // compare fault a, uart rx, uart cts, spi data, spi clock, spi ss
  localparam logic [ADDR_W-1:0] SEL_OFF [SEL_N] = '{
    OFF_EXT_INT_TWO, OFF_TIMER_CLOCK, OFF_TIMER_CLOCK,
    OFF_CAPTURE_LOW, OFF_CAPTURE_LOW, OFF_CAPTURE_HIGH,
    OFF_CAPTURE_HIGH, OFF_COMPARE_FLT, OFF_UART, OFF_UART,
    OFF_SPI_DATA_CLK, OFF_SPI_DATA_CLK, OFF_SPI_SELECT};
  localparam int SEL_LSB [SEL_N] = '{
    FIELD_LO, FIELD_LO, FIELD_HI, FIELD_LO, FIELD_HI, FIELD_LO,
    FIELD_HI, FIELD_LO, FIELD_LO, FIELD_HI, FIELD_LO, FIELD_HI,
    FIELD_LO};

  // Unlock sequence states
  typedef enum logic [1:0] {
    KEY_IDLE, KEY_ONE_SEEN, KEY_ARMED
  } key_state_e;

endpackage

// ### core/remappable_input_select.sv
// Purpose: Input half of the pin-select mux with AXI4-Lite registers
// Assumes: One master, one write and one read outstanding at most
// Notes:   Lock sequence, one-way lock and shadow check are local
//
// Summary of operation
// - Codes 0..15 route that pin
// - Code 31 ties input low
// - Selectors reset to all ones
// - Unimplemented bits read zero, ignore writes
// - Ext interrupt two in bits 4..0
// - Timer three high, timer two low
// - Capture two high, capture one low
// - Capture eight high, capture seven low
// - Compare fault a in bits 4..0
// - Uart cts high, uart receive low
// - Spi clock high, spi data low
// - Spi slave select in bits 4..0
// - Lock set: selector writes silently dropped
// - Lock changes only after 46, 57 keys
// - Shadow mismatch requests configuration reset
// - One-way config: lock stays until reset
`timescale 1ns/1ps
module remappable_input_select
  import pin_select_pkg::*;
(
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // AXI4-Lite write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Pins and configuration strap
  input  wire logic [PIN_N-1:0]  remappable_pin,
  input  wire logic              one_way_lock_config,
  // Peripheral inputs
  output logic                   ext_interrupt_two,
  output logic                   timer_two_ext_clock,
  output logic                   timer_three_ext_clock,
  output logic                   capture_channel_one,
  output logic                   capture_channel_two,
  output logic                   capture_channel_seven,
  output logic                   capture_channel_eight,
  output logic                   compare_fault_a_input,
  output logic                   uart_receive_in,
  output logic                   uart_clear_to_send_in,
  output logic                   spi_data_in,
  output logic                   spi_clock_in,
  output logic                   spi_slave_select_in,
  // Status toward the system
  output logic                   pin_select_write_lock,
  output logic                   config_mismatch_reset
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_N-1:0] sync1_q, sync2_q, sync3_q, filt_q, filt_d;

  // Accept a level only once stages two and three agree
  always_comb begin
    filt_d = (~(sync2_q ^ sync3_q) & sync3_q)
           | ((sync2_q ^ sync3_q) & filt_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q  <= '0;
    end else begin
      sync1_q <= remappable_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic              aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [ADDR_W-1:0] wa_q, wa_d;
  logic [31:0]       wd_q, wd_d;
  logic [3:0]        ws_q, ws_d;
  logic              bvalid_d, awready_d, wready_d;
  logic [1:0]        bresp_d;
  logic              do_wr, hit_wr;

  // Address and data may arrive in either order
  assign do_wr = aw_full_q && w_full_q && !bvalid;

  always_comb begin
    hit_wr = (wa_q == OFF_OSC_CONTROL);
    for (int i = 0; i < SEL_N; i++) begin
      if (SEL_OFF[i] == wa_q) hit_wr = 1'b1;
    end
  end

  always_comb begin
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    wa_d      = wa_q;
    wd_d      = wd_q;
    ws_d      = ws_q;
    bvalid_d  = bvalid;
    bresp_d   = bresp;
    if (awvalid && awready) begin
      aw_full_d = 1'b1;
      wa_d      = awaddr;
    end
    if (wvalid && wready) begin
      w_full_d = 1'b1;
      wd_d     = wdata;
      ws_d     = wstrb;
    end
    if (bvalid && bready) begin
      bvalid_d = 1'b0;
    end
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      // Locked writes still answer OKAY
      bresp_d   = hit_wr ? RESP_OKAY : RESP_SLVERR;
    end
    awready_d = !aw_full_d;
    wready_d  = !w_full_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      wa_q      <= '0;
      wd_q      <= '0;
      ws_q      <= '0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      awready   <= 1'b0;
      wready    <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      wa_q      <= wa_d;
      wd_q      <= wd_d;
      ws_q      <= ws_d;
      bvalid    <= bvalid_d;
      bresp     <= bresp_d;
      awready   <= awready_d;
      wready    <= wready_d;
    end
  end

  // ----------------------------------------------------------------
  // Lock, unlock keys and one-way strap
  // ----------------------------------------------------------------
  key_state_e key_q, key_d;
  logic       lock_q, lock_d, one_way_q, strap_done_q;
  logic       ctrl_wr;

  assign ctrl_wr = do_wr && (wa_q == OFF_OSC_CONTROL) && ws_q[0];

  // Any write that breaks the key chain drops back to idle
  always_comb begin
    key_d  = key_q;
    lock_d = lock_q;
    if (do_wr) begin
      key_d = KEY_IDLE;
      if (ctrl_wr) begin
        case (key_q)
          KEY_IDLE: begin
            if (wd_q[7:0] == UNLOCK_KEY_ONE) key_d = KEY_ONE_SEEN;
          end
          KEY_ONE_SEEN: begin
            if (wd_q[7:0] == UNLOCK_KEY_TWO) key_d = KEY_ARMED;
          end
          KEY_ARMED: begin
            // One-way mode keeps a set lock until reset
            if (!(one_way_q && lock_q)) begin
              lock_d = wd_q[LOCK_BIT];
            end
          end
          default: key_d = KEY_IDLE;
        endcase
      end
    end
  end

  // Strap is caught after reset release, never under reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_q        <= KEY_IDLE;
      lock_q       <= 1'b0;
      one_way_q    <= 1'b1;
      strap_done_q <= 1'b0;
    end else begin
      key_q        <= key_d;
      lock_q       <= lock_d;
      strap_done_q <= 1'b1;
      if (!strap_done_q) one_way_q <= one_way_lock_config;
    end
  end

  assign pin_select_write_lock = lock_q;

  // ----------------------------------------------------------------
  // Selector fields and shadows
  // ----------------------------------------------------------------
  logic [SEL_W-1:0] sel_q [SEL_N];
  logic [SEL_W-1:0] sel_d [SEL_N];
  logic [SEL_W-1:0] shadow_q [SEL_N];
  logic             mismatch_d;

  // Only the five field bits exist; other bits are dropped
  always_comb begin
    for (int i = 0; i < SEL_N; i++) begin
      sel_d[i] = sel_q[i];
      if (do_wr && !lock_q && SEL_OFF[i] == wa_q
          && ws_q[SEL_LSB[i]/8]) begin
        sel_d[i] = wd_q[SEL_LSB[i] +: SEL_W];
      end
    end
  end

  // Shadows load with the field; disagreement means upset
  always_comb begin
    mismatch_d = config_mismatch_reset;
    for (int i = 0; i < SEL_N; i++) begin
      if (sel_q[i] != shadow_q[i]) mismatch_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < SEL_N; i++) begin
        sel_q[i]    <= SEL_RESET;
        shadow_q[i] <= SEL_RESET;
      end
      config_mismatch_reset <= 1'b0;
    end else begin
      for (int i = 0; i < SEL_N; i++) begin
        sel_q[i]    <= sel_d[i];
        shadow_q[i] <= sel_d[i];
      end
      config_mismatch_reset <= mismatch_d;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [REG_W-1:0] rd_word;
  logic             rd_hit, rvalid_d, arready_d;
  logic [31:0]      rdata_d;
  logic [1:0]       rresp_d;

  // Fields OR into place; everything else stays zero
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b0;
    for (int i = 0; i < SEL_N; i++) begin
      if (SEL_OFF[i] == araddr) begin
        rd_word[SEL_LSB[i] +: SEL_W] = sel_q[i];
        rd_hit = 1'b1;
      end
    end
    if (araddr == OFF_OSC_CONTROL) begin
      rd_word[LOCK_BIT]    = lock_q;
      rd_word[ONE_WAY_BIT] = one_way_q;
      rd_hit = 1'b1;
    end
  end

  always_comb begin
    rvalid_d  = rvalid;
    rdata_d   = rdata;
    rresp_d   = rresp;
    arready_d = !rvalid; // Idle after reset must accept a read
    if (rvalid && rready) begin
      rvalid_d  = 1'b0;
      arready_d = 1'b1;
    end
    if (arvalid && arready) begin
      rvalid_d  = 1'b1;
      arready_d = 1'b0;
      rdata_d   = {16'h0000, rd_word};
      rresp_d   = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
      arready <= 1'b0;
    end else begin
      rvalid  <= rvalid_d;
      rdata   <= rdata_d;
      rresp   <= rresp_d;
      arready <= arready_d;
    end
  end

  // ----------------------------------------------------------------
  // Routing muxes, one per peripheral input
  // ----------------------------------------------------------------
  logic [SEL_N-1:0] route;

  for (genvar g = 0; g < SEL_N; g++) begin : g_route
    pin_route_mux u_mux (
      .aclk    (aclk),
      .aresetn (aresetn),
      .sel     (sel_q[g]),
      .pins    (filt_q),
      .route_q (route[g])
    );
  end

  // Field placement per register
  assign ext_interrupt_two     = route[0];
  assign timer_two_ext_clock   = route[1];
  assign timer_three_ext_clock = route[2];
  assign capture_channel_one   = route[3];
  assign capture_channel_two   = route[4];
  assign capture_channel_seven = route[5];
  assign capture_channel_eight = route[6];
  assign compare_fault_a_input = route[7];
  assign uart_receive_in       = route[8];
  assign uart_clear_to_send_in = route[9];
  assign spi_data_in           = route[10];
  assign spi_clock_in          = route[11];
  assign spi_slave_select_in   = route[12];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic pick0, all_ones, wr_sel0;
  logic [SEL_N*SEL_W-1:0] sel_flat, shadow_flat;
  assign pick0   = filt_q[sel_q[0][SEL_W-2:0]];
  assign wr_sel0 = do_wr && !lock_q && wa_q == OFF_EXT_INT_TWO && ws_q[0];
  always_comb begin
    all_ones = 1'b1;
    for (int i = 0; i < SEL_N; i++) begin
      sel_flat[i*SEL_W +: SEL_W]    = sel_q[i];
      shadow_flat[i*SEL_W +: SEL_W] = shadow_q[i];
      if (sel_q[i] != SEL_RESET) all_ones = 1'b0;
    end
  end

  sequence s_unlocked_wr0;
    wr_sel0;
  endsequence
  sequence s_locked_wr;
    do_wr && lock_q;
  endsequence

  property p_pin_route;
    !sel_q[0][SEL_W-1] |=> ext_interrupt_two == $past(pick0);
  endproperty
  a_pin_route: assert property (p_pin_route)
    else $error("routed pin does not reach peripheral input");

  property p_ground;
    sel_q[3] == SEL_RESET |=> !capture_channel_one;
  endproperty
  a_ground: assert property (p_ground)
    else $error("code 31 did not tie input low");

  property p_reset_ones;
    $rose(aresetn) |-> all_ones;
  endproperty
  a_reset_ones: assert property (@(posedge aclk) p_reset_ones)
    else $error("selectors not all ones after reset");

  property p_read_zero;
    rvalid |-> rdata[31:13] == '0 && rdata[7:0] == (rdata[7:0] & 8'h7F);
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("unimplemented read bits not zero");

  property p_lock_hold;
    s_locked_wr |=> $stable(sel_flat);
  endproperty
  a_lock_hold: assert property (p_lock_hold)
    else $error("selector changed while locked");

  property p_key_gate;
    $changed(lock_q) |-> $past(key_q) == KEY_ARMED;
  endproperty
  a_key_gate: assert property (p_key_gate)
    else $error("lock changed without key sequence");

  property p_mismatch;
    sel_flat != shadow_flat |=> config_mismatch_reset;
  endproperty
  a_mismatch: assert property (p_mismatch)
    else $error("shadow mismatch did not request reset");

  property p_one_way;
    one_way_q && lock_q |=> lock_q [*2];
  endproperty
  a_one_way: assert property (p_one_way)
    else $error("one-way lock was cleared");

  property p_undefined;
    sel_q[8][SEL_W-1] |=> !uart_receive_in;
  endproperty
  a_undefined: assert property (p_undefined)
    else $error("undefined code did not tie low");

  property p_write_next;
    s_unlocked_wr0 |=> sel_q[0] == $past(wd_q[SEL_W-1:0]);
  endproperty
  a_write_next: assert property (p_write_next)
    else $error("selector write did not apply next edge");

endmodule

// ### verification/pin_source_model.sv
// Purpose: Far-side model driving the remappable pins
// Assumes: Pattern chosen by the bench, applied after a clock edge
// Notes:   Pins change once per edge, like real board logic
`timescale 1ns/1ps
module pin_source_model
  import pin_select_pkg::*;
(
  // Clock
  input  wire logic             aclk,
  // Requested pin levels
  input  wire logic [PIN_N-1:0] pattern,
  // Driven pins
  output logic      [PIN_N-1:0] pins
);
  // Registered so pins never move in the sampling step
  always_ff @(posedge aclk) begin
    pins <= pattern;
  end
endmodule

// ### verification/tb_remappable_input_select.sv
// Purpose: Self-checking bench for the remappable input selector
// Assumes: AXI4-Lite master tasks, LFSR stimulus, 100 ns clock
// Notes:   Expected values come from a local selector model
`timescale 1ns/1ps
module tb_remappable_input_select
  import pin_select_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0, one_way = 1'b1;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = '0;
  logic              awready, wready, bvalid, arready, rvalid, lock_o, mism;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic [PIN_N-1:0]  pattern = '0;
  logic [PIN_N-1:0]  pins;
  logic [SEL_N-1:0]  periph;
  logic [SEL_W-1:0]  sel_m [SEL_N];
  logic [31:0]       seed = 32'h6165DE8F;
  int                bad_count = 0;
  int                n_checks = 0;

  always #50 aclk = ~aclk;

  logic ext_interrupt_two, timer_two_ext_clock, timer_three_ext_clock;
  logic capture_channel_one, capture_channel_two, capture_channel_seven;
  logic capture_channel_eight, compare_fault_a_input, uart_receive_in;
  logic uart_clear_to_send_in, spi_data_in, spi_clock_in, spi_slave_select_in;

  // Peripheral inputs in package selector order
  assign periph = {spi_slave_select_in, spi_clock_in, spi_data_in, uart_clear_to_send_in,
                   uart_receive_in, compare_fault_a_input, capture_channel_eight,
                   capture_channel_seven, capture_channel_two, capture_channel_one,
                   timer_three_ext_clock, timer_two_ext_clock, ext_interrupt_two};

  pin_source_model pin_source_model_i (.aclk(aclk), .pattern(pattern), .pins(pins));

  remappable_input_select remappable_input_select_i (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .remappable_pin(pins),
    .one_way_lock_config(one_way), .ext_interrupt_two(ext_interrupt_two),
    .timer_two_ext_clock(timer_two_ext_clock),
    .timer_three_ext_clock(timer_three_ext_clock),
    .capture_channel_one(capture_channel_one), .capture_channel_two(capture_channel_two),
    .capture_channel_seven(capture_channel_seven),
    .capture_channel_eight(capture_channel_eight),
    .compare_fault_a_input(compare_fault_a_input), .uart_receive_in(uart_receive_in),
    .uart_clear_to_send_in(uart_clear_to_send_in), .spi_data_in(spi_data_in),
    .spi_clock_in(spi_clock_in), .spi_slave_select_in(spi_slave_select_in),
    .pin_select_write_lock(lock_o), .config_mismatch_reset(mism));

  // ----------------------------------------------------------------
  // Model functions
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // Register image built from the selector model
  function automatic logic [15:0] reg_exp(input logic [ADDR_W-1:0] off);
    logic [15:0] v;
    v = '0;
    for (int i = 0; i < SEL_N; i++) if (SEL_OFF[i] == off) v |= 16'(sel_m[i]) << SEL_LSB[i];
    return v;
  endfunction

  // Codes above fifteen must give a constant low
  function automatic logic route_exp(input int i);
    return (sel_m[i] < 5'h10) ? pattern[sel_m[i][3:0]] : 1'b0;
  endfunction

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Leading edge keeps a release and a new request out of one step
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int   t;
    logic aw_ok, w_ok;
    @(posedge aclk);
    t = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok) && t < 50) begin
      @(posedge aclk);
      t++;
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
      t++;
    end while (bvalid !== 1'b1 && t < 100);
    r = bresp;
    bready <= 1'b0;
    if (t >= 100) bad_count++;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge aclk);
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      t++;
    end while (arready !== 1'b1 && t < 50);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1 && t < 100) begin
      @(posedge aclk);
      t++;
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (t >= 100) bad_count++;
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Software side of the unlock handshake
  task automatic key_write(input logic [31:0] v);
    logic [1:0] r;
    wr(OFF_OSC_CONTROL, 32'(UNLOCK_KEY_ONE), r);
    wr(OFF_OSC_CONTROL, 32'(UNLOCK_KEY_TWO), r);
    wr(OFF_OSC_CONTROL, v, r);
  endtask

  task automatic check_regs();
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 8; k++) begin
      rd(6'(k * 4), d, r);
      check(d, {16'h0, reg_exp(6'(k * 4))});
      check(32'(r), 32'(RESP_OKAY));
    end
  endtask

  // Garbage in unimplemented bits must be dropped
  task automatic write_all();
    logic [31:0] v;
    logic [15:0] e;
    logic [1:0]  r;
    for (int k = 0; k < 8; k++) begin
      v = rnd();
      e = reg_exp(6'(k * 4));
      wr(6'(k * 4), {v[31:16], v[15:13], e[12:8], v[7:5], e[4:0]}, r);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d, v;
    logic [1:0]  r;
    for (int i = 0; i < SEL_N; i++) sel_m[i] = SEL_RESET;
    do_reset();
    check(32'(periph), 32'h0);
    check_regs();
    wr(6'h3C, rnd(), r);
    check(32'(r), 32'(RESP_SLVERR));
    rd(6'h3C, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    check(d, 32'h0);
    // Corner code sets first, then random ones
    for (int t = 0; t < 8; t++) begin
      for (int i = 0; i < SEL_N; i++) begin
        v = rnd();
        sel_m[i] = (t == 0) ? 5'((i * 5) % 32) : (t == 1) ? 5'(31 - i) : v[4:0];
      end
      write_all();
      check_regs();
      for (int p = 0; p < 2; p++) begin
        v = rnd();
        pattern <= v[15:0];
        repeat (10) @(posedge aclk);
        for (int i = 0; i < SEL_N; i++) check(32'(periph[i]), 32'(route_exp(i)));
      end
    end
    wr(OFF_OSC_CONTROL, 32'h40, r);
    check(32'(lock_o), 32'h0);
    key_write(32'h40);
    check(32'(lock_o), 32'h1);
    rd(OFF_OSC_CONTROL, d, r);
    check(32'(d[LOCK_BIT]), 32'h1);
    wr(OFF_TIMER_CLOCK, 32'h0, r);
    check(32'(r), 32'(RESP_OKAY));
    check_regs();
    key_write(32'h0);
    check(32'(lock_o), 32'h1);
    one_way <= 1'b0;
    for (int i = 0; i < SEL_N; i++) sel_m[i] = SEL_RESET;
    do_reset();
    check_regs();
    key_write(32'h40);
    key_write(32'h0);
    check(32'(lock_o), 32'h0);
    wr(OFF_TIMER_CLOCK, 32'h0305, r);
    sel_m[1] = 5'h05;
    sel_m[2] = 5'h03;
    check_regs();
    check(32'(mism), 32'h0);
    summarize();
  end

  // Hang guard, far beyond the thousand or so cycles needed
  initial begin
    #(100 * 20000);
    $display("timeout reached");
    bad_count++;
    summarize();
  end
endmodule
